// *** include/exvms_params.svh ***
// constants for the exception vector and mode stack block
`ifndef EXVMS_PARAMS_SVH
`define EXVMS_PARAMS_SVH

`define EXVMS_STATE_WORDS   6'h23
`define EXVMS_STATE_LAST    6'h22
`define EXVMS_CTX_WORDS     6'h03

`define EXVMS_IDX_STATUS    6'h02
`define EXVMS_IDX_PC        6'h03
`define EXVMS_IDX_T9        6'h1c
`define EXVMS_IDX_SP        6'h20

`define EXVMS_ADDR_CMD        12'h000
`define EXVMS_ADDR_STATUS     12'h004
`define EXVMS_ADDR_PC         12'h008
`define EXVMS_ADDR_EPC        12'h00c
`define EXVMS_ADDR_CPU_RUN    12'h010
`define EXVMS_ADDR_IRQ_STAT   12'h014
`define EXVMS_ADDR_IRQ_MASK   12'h018
`define EXVMS_ADDR_STAGE_IDX  12'h01c
`define EXVMS_ADDR_STAGE_DATA 12'h020
`define EXVMS_ADDR_VIEW_IDX   12'h024
`define EXVMS_ADDR_VIEW_DATA  12'h028

`define EXVMS_CMD_EXC       0
`define EXVMS_CMD_REFILL    1
`define EXVMS_CMD_RFE       2
`define EXVMS_CMD_FULL      3
`define EXVMS_CMD_CTX       4
`define EXVMS_CMD_BUSY      5

`define EXVMS_ST_IEC        0
`define EXVMS_ST_KUC        1
`define EXVMS_ST_IEP        2
`define EXVMS_ST_KUP        3
`define EXVMS_ST_IEO        4
`define EXVMS_ST_KUO        5
`define EXVMS_ST_BEV        22

`define EXVMS_IRQ_EXC       0
`define EXVMS_IRQ_LOAD      1

`define EXVMS_RESET_PC      32'h1fc0_0000
`define EXVMS_RESET_STATUS  32'h1040_0000
`define EXVMS_RESET_CPU_RUN 16'h0001
`define EXVMS_VEC_REFILL    32'h0000_0000
`define EXVMS_VEC_EXC       32'h0000_0080
`define EXVMS_VEC_BREFILL   32'h1fc0_0100
`define EXVMS_VEC_BEXC      32'h1fc0_0180

`endif

// *** include/exvms_pkg.sv ***
// types for the exception vector and mode stack block
package exvms_pkg;

    typedef enum logic [1:0] {
        EXVMS_IDLE,
        EXVMS_LOAD,
        EXVMS_JUMP
    } exvms_fsm_t;

    typedef struct packed {
        logic        we;
        logic [5:0]  addr;
        logic [31:0] data;
    } exvms_memwr_t;

    typedef struct packed {
        exvms_fsm_t   fsm;
        logic         full;
        logic [5:0]   step;
        logic         rd_vld;
        logic [5:0]   rd_idx;
        logic         wr_vld;
        logic [5:0]   wr_idx;
        logic [31:0]  new_pc;
        logic [31:0]  new_status;
        logic [31:0]  pc;
        logic [31:0]  status;
        logic [31:0]  epc;
        logic [15:0]  cpu_run;
        logic [1:0]   irq_stat;
        logic [1:0]   irq_mask;
        logic [5:0]   stage_idx;
        logic [5:0]   view_idx;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
        logic         irq;
        logic         busy;
        exvms_memwr_t arch_wr;
        exvms_memwr_t stage_wr;
    } exvms_regs_t;

endpackage

// *** verilog/exvms_state_mem.sv ***
// 35-word processor state store with registered read data
`timescale 1ns/1ps
`include "exvms_params.svh"
module exvms_state_mem
    import exvms_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire exvms_memwr_t wr,
    input  wire logic [5:0]   raddr,
    output logic [31:0]       rdata_ff
);
    logic [31:0] mem_ff [0:34];

    // cleared at reset so every register outside pc and status starts at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 35; i++) begin
                mem_ff[i] <= 32'h0000_0000;
            end
            rdata_ff <= 32'h0000_0000;
        end else begin
            if (wr.we && wr.addr <= `EXVMS_STATE_LAST) begin
                mem_ff[wr.addr] <= wr.data;
            end
            rdata_ff <= (raddr <= `EXVMS_STATE_LAST) ? mem_ff[raddr] : 32'h0000_0000;
        end
    end
endmodule

// *** verilog/exvms_top.sv ***
// exception entry, vector select, mode stack and state load sequencer
//
// Overview of operation
// - A return from exception pops the stack so previous mode and enable become current.
// - The pop leaves the oldest mode and enable bits unchanged.
// - After reset only processor 0 runs and others wait for an explicit start.
// - Reset loads the program counter with the bootstrap entry address.
// - Reset loads the status register with its documented boot value.
// - Reset clears every other general and control register except the run enables to zero.
// - With the bootstrap vector bit clear a refill event vectors to the low refill address.
// - With the bootstrap vector bit clear other exceptions vector to the low general address.
// - With the bootstrap vector bit set events vector to the two bootstrap addresses.
// - Full load replaces all 35 state words; context load only pc, t9, sp and status.
// - Loads write word by word with ints disabled, then jump and pop in one step.
`timescale 1ns/1ps
`include "exvms_params.svh"
module exvms_top
    import exvms_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             irq,
    output logic [31:0]      pc,
    output logic [31:0]      status,
    output logic [15:0]      cpu_run,
    output logic             busy
);
    exvms_regs_t r_ff;
    exvms_regs_t nxt_r;
    logic [31:0] stage_rdata;
    logic [31:0] view_rdata;

    function automatic logic addr_ok(input logic [11:0] a);
        unique case (a)
            `EXVMS_ADDR_CMD, `EXVMS_ADDR_STATUS, `EXVMS_ADDR_PC,
            `EXVMS_ADDR_EPC, `EXVMS_ADDR_CPU_RUN, `EXVMS_ADDR_IRQ_STAT,
            `EXVMS_ADDR_IRQ_MASK, `EXVMS_ADDR_STAGE_IDX,
            `EXVMS_ADDR_STAGE_DATA, `EXVMS_ADDR_VIEW_IDX,
            `EXVMS_ADDR_VIEW_DATA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // oldest level is left as it stands
    function automatic logic [31:0] stack_pop(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        v[`EXVMS_ST_KUC] = s[`EXVMS_ST_KUP];
        v[`EXVMS_ST_IEC] = s[`EXVMS_ST_IEP];
        v[`EXVMS_ST_KUP] = s[`EXVMS_ST_KUO];
        v[`EXVMS_ST_IEP] = s[`EXVMS_ST_IEO];
        v[`EXVMS_ST_KUO] = s[`EXVMS_ST_KUO];
        v[`EXVMS_ST_IEO] = s[`EXVMS_ST_IEO];
        return v;
    endfunction

    function automatic logic [31:0] stack_push(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        v[`EXVMS_ST_KUO] = s[`EXVMS_ST_KUP];
        v[`EXVMS_ST_IEO] = s[`EXVMS_ST_IEP];
        v[`EXVMS_ST_KUP] = s[`EXVMS_ST_KUC];
        v[`EXVMS_ST_IEP] = s[`EXVMS_ST_IEC];
        v[`EXVMS_ST_KUC] = 1'b0;
        v[`EXVMS_ST_IEC] = 1'b0;
        return v;
    endfunction

    function automatic logic [31:0] vector_of(input logic bootstrap_vector_select, input logic refill);
        if (bootstrap_vector_select) begin
            vector_of = refill ? `EXVMS_VEC_BREFILL : `EXVMS_VEC_BEXC;
        end else if (refill) begin
            vector_of = `EXVMS_VEC_REFILL;
        end else begin
            vector_of = `EXVMS_VEC_EXC;
        end
    endfunction

    // a context load visits only the three context words
    function automatic logic [5:0] load_idx(input logic full, input logic [5:0] step);
        if (full) begin
            load_idx = step;
        end else begin
            unique case (step[1:0])
                2'h0:    load_idx = `EXVMS_IDX_SP;
                2'h1:    load_idx = `EXVMS_IDX_PC;
                default: load_idx = `EXVMS_IDX_STATUS;
            endcase
        end
    endfunction

    exvms_state_mem u_stage (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr       (r_ff.stage_wr),
        .raddr    (r_ff.rd_idx),
        .rdata_ff (stage_rdata)
    );

    exvms_state_mem u_arch (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr       (r_ff.arch_wr),
        .raddr    (r_ff.view_idx),
        .rdata_ff (view_rdata)
    );

    always_comb begin
        logic        acc;
        logic        wr_go;
        logic        idle;
        logic [1:0]  clr;
        logic [1:0]  set;
        logic [5:0]  cnt;
        logic [31:0] rd;
        acc   = psel && penable;
        wr_go = acc && r_ff.pready && pwrite && !r_ff.pslverr;
        idle  = (r_ff.fsm == EXVMS_IDLE);
        clr   = 2'h0;
        set   = 2'h0;
        cnt   = r_ff.full ? `EXVMS_STATE_WORDS : `EXVMS_CTX_WORDS;
        rd    = 32'h0000_0000;
        nxt_r = r_ff;
        nxt_r.pready      = 1'b0;
        nxt_r.pslverr     = 1'b0;
        nxt_r.arch_wr.we  = 1'b0;
        nxt_r.stage_wr.we = 1'b0;
        nxt_r.rd_vld      = 1'b0;
        nxt_r.wr_vld      = r_ff.rd_vld;
        nxt_r.wr_idx      = r_ff.rd_idx;

        unique case (paddr)
            `EXVMS_ADDR_CMD:        rd[`EXVMS_CMD_BUSY] = r_ff.busy;
            `EXVMS_ADDR_STATUS:     rd = r_ff.status;
            `EXVMS_ADDR_PC:         rd = r_ff.pc;
            `EXVMS_ADDR_EPC:        rd = r_ff.epc;
            `EXVMS_ADDR_CPU_RUN:    rd[15:0] = r_ff.cpu_run;
            `EXVMS_ADDR_IRQ_STAT:   rd[1:0] = r_ff.irq_stat;
            `EXVMS_ADDR_IRQ_MASK:   rd[1:0] = r_ff.irq_mask;
            `EXVMS_ADDR_STAGE_IDX:  rd[5:0] = r_ff.stage_idx;
            `EXVMS_ADDR_VIEW_IDX:   rd[5:0] = r_ff.view_idx;
            `EXVMS_ADDR_VIEW_DATA:  rd = view_rdata;
            default:                rd = 32'h0000_0000;
        endcase

        // one wait state: the answer is built in the first access cycle
        if (acc && !r_ff.pready) begin
            nxt_r.pready  = 1'b1;
            nxt_r.pslverr = !addr_ok(paddr);
            nxt_r.prdata  = rd;
        end

        if (wr_go) begin
            unique case (paddr)
                `EXVMS_ADDR_CMD: begin
                    // commands are ignored while a load is running so it stays atomic
                    if (idle && pwdata[`EXVMS_CMD_EXC]) begin
                        nxt_r.epc    = r_ff.pc;
                        nxt_r.pc     = vector_of(r_ff.status[`EXVMS_ST_BEV],
                                                 pwdata[`EXVMS_CMD_REFILL]);
                        nxt_r.status = stack_push(r_ff.status);
                        set[`EXVMS_IRQ_EXC] = 1'b1;
                    end else if (idle && pwdata[`EXVMS_CMD_RFE]) begin
                        nxt_r.status = stack_pop(r_ff.status);
                    end else if (idle && (pwdata[`EXVMS_CMD_FULL] ||
                                          pwdata[`EXVMS_CMD_CTX])) begin
                        nxt_r.fsm  = EXVMS_LOAD;
                        nxt_r.full = pwdata[`EXVMS_CMD_FULL];
                        nxt_r.step = 6'h00;
                        nxt_r.busy = 1'b1;
                        nxt_r.new_pc     = r_ff.pc;
                        nxt_r.new_status = r_ff.status;
                        nxt_r.status[`EXVMS_ST_IEC] = 1'b0;
                    end
                end
                `EXVMS_ADDR_STATUS: begin
                    if (idle) begin
                        nxt_r.status = pwdata;
                    end
                end
                `EXVMS_ADDR_CPU_RUN: begin
                    // start only; a running processor is not stopped here
                    nxt_r.cpu_run = r_ff.cpu_run | pwdata[15:0];
                end
                `EXVMS_ADDR_IRQ_STAT: begin
                    clr = pwdata[1:0];
                end
                `EXVMS_ADDR_IRQ_MASK: begin
                    nxt_r.irq_mask = pwdata[1:0];
                end
                `EXVMS_ADDR_STAGE_IDX: begin
                    nxt_r.stage_idx = pwdata[5:0];
                end
                `EXVMS_ADDR_STAGE_DATA: begin
                    // software puts the wanted mode and enable in the previous slots
                    nxt_r.stage_wr.we   = 1'b1;
                    nxt_r.stage_wr.addr = r_ff.stage_idx;
                    nxt_r.stage_wr.data = pwdata;
                    nxt_r.stage_idx = (r_ff.stage_idx >= `EXVMS_STATE_LAST) ?
                                      6'h00 : r_ff.stage_idx + 6'h01;
                end
                `EXVMS_ADDR_VIEW_IDX: begin
                    nxt_r.view_idx = pwdata[5:0];
                end
                default: begin
                end
            endcase
        end

        unique case (r_ff.fsm)
            EXVMS_IDLE: begin
            end
            EXVMS_LOAD: begin
                // word by word copy, read latency of one cycle is pipelined
                if (r_ff.step < cnt) begin
                    nxt_r.rd_idx = load_idx(r_ff.full, r_ff.step);
                    nxt_r.rd_vld = 1'b1;
                    nxt_r.step   = r_ff.step + 6'h01;
                end
                if (r_ff.wr_vld) begin
                    if (r_ff.full) begin
                        nxt_r.arch_wr.we   = 1'b1;
                        nxt_r.arch_wr.addr = r_ff.wr_idx;
                        nxt_r.arch_wr.data = stage_rdata;
                    end else if (r_ff.wr_idx == `EXVMS_IDX_SP) begin
                        nxt_r.arch_wr.we   = 1'b1;
                        nxt_r.arch_wr.addr = `EXVMS_IDX_SP;
                        nxt_r.arch_wr.data = stage_rdata;
                    end else if (r_ff.wr_idx == `EXVMS_IDX_PC) begin
                        // the jump register mirrors the new pc
                        nxt_r.arch_wr.we   = 1'b1;
                        nxt_r.arch_wr.addr = `EXVMS_IDX_T9;
                        nxt_r.arch_wr.data = stage_rdata;
                    end
                    if (r_ff.wr_idx == `EXVMS_IDX_PC) begin
                        nxt_r.new_pc = stage_rdata;
                    end
                    if (r_ff.wr_idx == `EXVMS_IDX_STATUS) begin
                        nxt_r.new_status = stage_rdata;
                    end
                end
                if (r_ff.step == cnt && !r_ff.rd_vld && !r_ff.wr_vld) begin
                    nxt_r.fsm = EXVMS_JUMP;
                end
            end
            EXVMS_JUMP: begin
                // jump and pop land together, as in a delay slot
                nxt_r.pc     = r_ff.new_pc;
                nxt_r.status = stack_pop(r_ff.new_status);
                nxt_r.fsm    = EXVMS_IDLE;
                nxt_r.busy   = 1'b0;
                set[`EXVMS_IRQ_LOAD] = 1'b1;
            end
        endcase

        // a set in the same cycle as its clear wins
        nxt_r.irq_stat = (r_ff.irq_stat & ~clr) | set;
        nxt_r.irq      = |(nxt_r.irq_stat & nxt_r.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff            <= '0;
            r_ff.fsm        <= EXVMS_IDLE;
            r_ff.pc         <= `EXVMS_RESET_PC;
            r_ff.status     <= `EXVMS_RESET_STATUS;
            r_ff.cpu_run    <= `EXVMS_RESET_CPU_RUN;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign pready  = r_ff.pready;
    assign prdata  = r_ff.prdata;
    assign pslverr = r_ff.pslverr;
    assign irq     = r_ff.irq;
    assign pc      = r_ff.pc;
    assign status  = r_ff.status;
    assign cpu_run = r_ff.cpu_run;
    assign busy    = r_ff.busy;
endmodule

// *** tb/exvms_checker.sv ***
// port-level assertions for the exception vector and mode stack block
`timescale 1ns/1ps
`include "exvms_params.svh"
module exvms_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic [31:0] pc,
    input wire logic [31:0] status,
    input wire logic [15:0] cpu_run,
    input wire logic        busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic        acc_wr;
    logic        cmd_go;
    logic [31:0] exp_vec;
    assign acc_wr  = psel && penable && pready && pwrite;
    // busy blocks commands, so only an idle-time command write is a cause
    assign cmd_go  = acc_wr && paddr == `EXVMS_ADDR_CMD && !busy;
    assign exp_vec = status[`EXVMS_ST_BEV] ?
                     (pwdata[1] ? `EXVMS_VEC_BREFILL : `EXVMS_VEC_BEXC) :
                     (pwdata[1] ? `EXVMS_VEC_REFILL : `EXVMS_VEC_EXC);
    a_reset_state: assert property ($rose(presetn) |-> pc == `EXVMS_RESET_PC &&
        status == `EXVMS_RESET_STATUS && cpu_run == 16'h0001 && !busy)
        else $error("state after reset differs");
    a_vector_select: assert property (cmd_go && pwdata[0] |=> pc == $past(exp_vec))
        else $error("exception vector wrong");
    a_stack_push: assert property (cmd_go && pwdata[0] |=>
        status[5:0] == {$past(status[3:0]), 2'b00}) else $error("stack push wrong");
    a_stack_pop: assert property (cmd_go && !pwdata[0] && pwdata[2] |=>
        status[5:0] == {$past(status[5:4]), $past(status[5:2])}) else $error("stack pop wrong");
    a_load_start: assert property (cmd_go && pwdata[4:0] inside {5'h08, 5'h10, 5'h18} |=> busy)
        else $error("load did not start");
    a_load_ints_off: assert property (busy |-> !status[0])
        else $error("interrupts enabled during load");
    a_load_bounded: assert property ($rose(busy) |-> ##[1:60] !busy)
        else $error("load did not finish");
    a_run_held: assert property (!(acc_wr && paddr == `EXVMS_ADDR_CPU_RUN) |=> $stable(cpu_run))
        else $error("run enables changed without a write");
    a_run_or_in: assert property (acc_wr && paddr == `EXVMS_ADDR_CPU_RUN |=>
        cpu_run == ($past(cpu_run) | $past(pwdata[15:0]))) else $error("run enables not ored in");
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than a cycle");
    a_err_unmapped: assert property (psel && penable && pready && paddr > 12'h028 |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind exvms_top exvms_checker exvms_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .pc(pc), .status(status),
    .cpu_run(cpu_run), .busy(busy));

// *** tb/exvms_tb_top.sv ***
// self-checking bench for the exception vector and mode stack block
`timescale 1ns/1ps
`include "exvms_params.svh"
module exvms_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [31:0] pc;
    logic [31:0] status;
    logic [15:0] cpu_run;
    logic        busy;
    logic        last_err;
    int          err_count;
    int          cmp_count;
    localparam logic [31:0] case_st [4] = '{32'h1040_000d, 32'h1040_0009, 32'h1000_0002,
                                            32'h1000_0005};
    localparam logic [31:0] case_cmd [4] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0001,
                                             32'h0000_0003};
    localparam logic [31:0] case_pc [4] = '{`EXVMS_VEC_BREFILL, `EXVMS_VEC_BEXC,
                                            `EXVMS_VEC_EXC, `EXVMS_VEC_REFILL};
    localparam logic [31:0] case_res [4] = '{32'h1040_0034, 32'h1040_0024, 32'h1000_0008,
                                             32'h1000_0014};

    exvms_top exvms_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .pc(pc), .status(status), .cpu_run(cpu_run), .busy(busy));

    always #50 pclk = ~pclk;

    // staged words; status asks for user mode with ints on via the previous slots
    function automatic logic [31:0] stage_val(input int i);
        if (i == 2) return 32'h1000_000c;
        if (i == 3) return 32'h0000_4000;
        return 32'ha5a5_0000 + 32'(i);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask

    task automatic view(input int i, input logic [31:0] exp);
        wr(`EXVMS_ADDR_VIEW_IDX, 32'(i));
        rd(`EXVMS_ADDR_VIEW_DATA, exp);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (busy !== 1'b0) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pc, `EXVMS_RESET_PC);
        chk(status, `EXVMS_RESET_STATUS);
        chk({16'h0000, cpu_run}, 32'h0000_0001);
        rd(`EXVMS_ADDR_EPC, 32'h0000_0000);
        rd(`EXVMS_ADDR_IRQ_MASK, 32'h0000_0000);
        for (int i = 0; i < 35; i++) begin
            view(i, 32'h0000_0000);
        end
        rd(12'h030, 32'h0000_0000);
        chk({31'h0, last_err}, 32'h0000_0001);
        $display("test reset state finished");
        for (int k = 0; k < 4; k++) begin
            wr(`EXVMS_ADDR_STATUS, case_st[k]);
            wr(`EXVMS_ADDR_CMD, case_cmd[k]);
            chk(pc, case_pc[k]);
            chk(status, case_res[k]);
        end
        rd(`EXVMS_ADDR_EPC, `EXVMS_VEC_EXC);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`EXVMS_ADDR_STATUS, 32'h1000_0039);
        wr(`EXVMS_ADDR_CMD, 32'h0000_0004);
        chk(status, 32'h1000_003e);
        $display("test vectors and stack finished");
        wr(`EXVMS_ADDR_STAGE_IDX, 32'h0000_0000);
        for (int i = 0; i < 35; i++) begin
            wr(`EXVMS_ADDR_STAGE_DATA, stage_val(i));
        end
        wr(`EXVMS_ADDR_CMD, 32'h0000_0010);
        chk({31'h0, busy}, 32'h0000_0001);
        rd(`EXVMS_ADDR_CMD, 32'h0000_0020);
        wait_idle();
        rd(`EXVMS_ADDR_CMD, 32'h0000_0000);
        chk(pc, stage_val(3));
        chk(status, 32'h1000_0003);
        view(32, stage_val(32));
        view(28, stage_val(3));
        view(0, 32'h0000_0000);
        // both load bits set: the full load takes priority
        wr(`EXVMS_ADDR_CMD, 32'h0000_0018);
        wait_idle();
        for (int i = 0; i < 35; i++) begin
            if (i != 2) begin
                view(i, stage_val(i));
            end
        end
        $display("test state loads finished");
        rd(`EXVMS_ADDR_IRQ_STAT, 32'h0000_0003);
        wr(`EXVMS_ADDR_IRQ_MASK, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`EXVMS_ADDR_IRQ_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`EXVMS_ADDR_IRQ_STAT, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`EXVMS_ADDR_CPU_RUN, 32'h0000_0004);
        rd(`EXVMS_ADDR_CPU_RUN, 32'h0000_0005);
        $display("test interrupt and run enables finished");
        tally_and_finish();
    end
endmodule
